// ---- rtl/cdc_fifo.sv ----
// Dual-clock FIFO, gray pointers; DEPTH must be a power of two
module cdc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic wr_clk_i,
  input wire logic wr_rst_i,
  stream_if.snk wr,
  input wire logic rd_clk_i,
  input wire logic rd_rst_i,
  stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_XOR = {2'b11, {(AW - 1){1'b0}}};

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
  logic [AW:0] wg_s1_q, wg_s2_q, rg_s1_q, rg_s2_q;
  logic full_s, empty_s, push_s, pop_s;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  assign full_s = (wgray_q == (rg_s2_q ^ FULL_XOR));
  assign empty_s = (rgray_q == wg_s2_q);
  assign wr.ready = ~full_s;
  assign rd.valid = ~empty_s;
  assign rd.data = mem_q[rbin_q[AW-1:0]];
  assign push_s = wr.valid & ~full_s;
  assign pop_s = rd.ready & ~empty_s;

  always_ff @(posedge wr_clk_i) begin
    if (push_s) begin
      mem_q[wbin_q[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
    if (wr_rst_i) begin
      wbin_q <= '0;
      wgray_q <= '0;
    end else if (push_s) begin
      wbin_q <= wbin_q + 1'b1;
      wgray_q <= bin2gray(wbin_q + 1'b1);
    end
  end

  always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
    if (rd_rst_i) begin
      rbin_q <= '0;
      rgray_q <= '0;
    end else if (pop_s) begin
      rbin_q <= rbin_q + 1'b1;
      rgray_q <= bin2gray(rbin_q + 1'b1);
    end
  end

  // Only gray codes cross, one bit changes per step
  always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
    if (rd_rst_i) begin
      wg_s1_q <= '0;
      wg_s2_q <= '0;
    end else begin
      wg_s1_q <= wgray_q;
      wg_s2_q <= wg_s1_q;
    end
  end

  always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
    if (wr_rst_i) begin
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end else begin
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
    end
  end
endmodule : cdc_fifo

// ---- rtl/stream_if.sv ----
interface stream_if #(
  parameter int W = 8
) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// ---- rtl/tof_out_pkg.sv ----
package tof_out_pkg;
  // Pixel and output word widths
  localparam int PIX_W = 12;
  localparam int WORD_W = 16;
  localparam int NUM_W = 4;
  // Frame identification word layout
  localparam logic [7:0] ID_PATTERN = 8'h55;
  localparam int ID_PAT_LSB = 8;
  localparam int ID_SF_LSB = 4;
  localparam int ID_Q_LSB = 0;
  // Marker indices
  localparam int MARK_N = 4;
  localparam int MARK_FRAME = 0;
  localparam int MARK_SUB = 1;
  localparam int MARK_QUAD = 2;
  localparam int MARK_ROW = 3;
  localparam int POS_W = 4;
  // FIFO entry layout: markers, id flag, word
  localparam int ENT_ID_BIT = 16;
  localparam int ENT_MARK_LSB = 17;
  localparam int ENT_W = 21;
  localparam int FIFO_DEPTH = 4;
  // Serial framing: two bits per link cycle
  localparam logic [2:0] SER_LAST = 3'h5;
  localparam logic [2:0] SER_HALF = 3'h3;
  localparam logic [2:0] SER_ID_BEAT = 3'h4;
  localparam logic [1:0] LRST_INIT = 2'h3;
endpackage : tof_out_pkg

// ---- rtl/tof_pixel_output.sv ----
// What this block does
// - Four marker outputs (frame, sub-frame, quad, row) travel with the data, each at a programmable position.
// - In serial mode the results go out on three data lanes plus one pixel clock lane.
// - The two difference lanes carry the tap difference A minus B, twelve bits per pixel.
// - The pixel clock is low for the first six bits of a pixel and high for the last six.
// - In serial mode one lane carries the even-numbered bits and the other the odd-numbered bits.
// - In parallel mode data changes on both edges of an output clock that runs at half the link clock rate.
// - The first word after each quad start marker is a frame identification word, ahead of any pixel.
// - The identification word holds 0101_0101 on top, then the sub-frame number, then the quad number.
module tof_pixel_output #(
  parameter int FIFO_DEPTH = tof_out_pkg::FIFO_DEPTH,
  parameter int POS_W = tof_out_pkg::POS_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic serial_mode_i,
  input wire logic [POS_W-1:0] pos_frame_i,
  input wire logic [POS_W-1:0] pos_subframe_i,
  input wire logic [POS_W-1:0] pos_quad_i,
  input wire logic [POS_W-1:0] pos_row_i,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire logic [tof_out_pkg::PIX_W-1:0] tap_a_i,
  input wire logic [tof_out_pkg::PIX_W-1:0] tap_b_i,
  input wire logic frame_start_i,
  input wire logic subframe_start_i,
  input wire logic quad_start_i,
  input wire logic row_start_i,
  input wire logic [tof_out_pkg::NUM_W-1:0] subframe_number_i,
  input wire logic [tof_out_pkg::NUM_W-1:0] quad_number_i,
  output logic diff_lane_even_o,
  output logic diff_lane_odd_o,
  output logic aux_lane_o,
  output logic pixel_clk_o,
  output logic cmos_clk_o,
  output logic [tof_out_pkg::WORD_W-1:0] cmos_data_o,
  output logic cmos_valid_o,
  output logic frame_marker_o,
  output logic subframe_marker_o,
  output logic quad_marker_o,
  output logic row_marker_o
);
  typedef enum logic [1:0] {st_idle, st_serial, st_cmos} link_state_e;

  stream_if #(.W(tof_out_pkg::ENT_W)) wr_if ();
  stream_if #(.W(tof_out_pkg::ENT_W)) rd_if ();

  // ---------------- System clock side ----------------
  logic hold_valid_q, id_pend_q, hold_next_s, accept_s, push_s;
  logic [tof_out_pkg::PIX_W-1:0] diff_q;
  logic [tof_out_pkg::MARK_N-1:0] flags_q, ev_s, mark_s;
  logic [tof_out_pkg::NUM_W-1:0] sf_q, quad_q;
  logic [tof_out_pkg::WORD_W-1:0] word_s;
  logic [POS_W-1:0] pos_s [tof_out_pkg::MARK_N];
  logic [POS_W-1:0] cnt_q [tof_out_pkg::MARK_N];
  logic [tof_out_pkg::MARK_N-1:0] armed_q;

  assign pos_s[tof_out_pkg::MARK_FRAME] = pos_frame_i;
  assign pos_s[tof_out_pkg::MARK_SUB] = pos_subframe_i;
  assign pos_s[tof_out_pkg::MARK_QUAD] = pos_quad_i;
  assign pos_s[tof_out_pkg::MARK_ROW] = pos_row_i;

  assign accept_s = pix_valid_i & pix_ready_o;
  assign push_s = hold_valid_q & wr_if.ready;
  // Holding register frees after its pixel word, not after the id word
  assign hold_next_s = accept_s | (hold_valid_q & ~(push_s & ~id_pend_q));
  // Id word takes frame/sub/quad events; the pixel word takes what is left
  assign ev_s = id_pend_q ? {1'b0, flags_q[tof_out_pkg::MARK_QUAD:0]} : flags_q;

  always_comb begin
    if (id_pend_q) begin
      word_s = {tof_out_pkg::ID_PATTERN, sf_q, quad_q};
    end else begin
      word_s = {{(tof_out_pkg::WORD_W - tof_out_pkg::PIX_W){1'b0}}, diff_q};
    end
  end

  assign wr_if.valid = hold_valid_q;
  assign wr_if.data = {mark_s, id_pend_q, word_s};

  // Ready is a flop mirroring the holding register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_valid_q <= 1'b0;
      pix_ready_o <= 1'b1;
    end else begin
      hold_valid_q <= hold_next_s;
      pix_ready_o <= ~hold_next_s;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      diff_q <= '0;
      flags_q <= '0;
      sf_q <= '0;
      quad_q <= '0;
      id_pend_q <= 1'b0;
    end else if (accept_s) begin
      diff_q <= tap_a_i - tap_b_i;
      flags_q <= {row_start_i, quad_start_i, subframe_start_i, frame_start_i};
      sf_q <= subframe_number_i;
      quad_q <= quad_number_i;
      // id word goes ahead of the pixel
      id_pend_q <= quad_start_i;
    end else if (push_s && id_pend_q) begin
      id_pend_q <= 1'b0;
      flags_q[tof_out_pkg::MARK_QUAD:0] <= '0;
    end
  end

  for (genvar i = 0; i < tof_out_pkg::MARK_N; i++) begin : g_mark
    assign mark_s[i] = push_s & ((ev_s[i] & (pos_s[i] == '0)) | (armed_q[i] & (cnt_q[i] == POS_W'(1))));

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        armed_q[i] <= 1'b0;
        cnt_q[i] <= '0;
      end else if (push_s) begin
        if (ev_s[i] && pos_s[i] != '0) begin
          armed_q[i] <= 1'b1;
          cnt_q[i] <= pos_s[i];
        end else if (armed_q[i]) begin
          cnt_q[i] <= cnt_q[i] - 1'b1;
          armed_q[i] <= (cnt_q[i] != POS_W'(1));
        end
      end
    end
  end

  a_accept_diff: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    accept_s |=> diff_q == tof_out_pkg::PIX_W'($past(tap_a_i) - $past(tap_b_i)))
    else $error("stored value is not tap A minus tap B");

  a_quad_id_first: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    accept_s && quad_start_i |=> hold_valid_q && id_pend_q && wr_if.data[tof_out_pkg::ENT_ID_BIT])
    else $error("quad start not led by an id word");

  a_id_format: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    push_s && id_pend_q |-> wr_if.data[15:8] == 8'h55 && wr_if.data[7:4] == sf_q && wr_if.data[3:0] == quad_q)
    else $error("id word layout wrong");

  a_pixel_after_id: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    push_s && id_pend_q |=> hold_valid_q && !id_pend_q && !pix_ready_o)
    else $error("pixel not kept after id word");

  // Link-side reset, retimed further down
  logic [1:0] link_rst_q;

  cdc_fifo #(
    .W(tof_out_pkg::ENT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .wr_clk_i(ref_clk_i),
    .wr_rst_i(rst_i),
    .wr(wr_if),
    .rd_clk_i(link_clk_i),
    .rd_rst_i(link_rst_q[1]),
    .rd(rd_if)
  );

  // ---------------- Link clock side ----------------
  logic mode_s1_q, mode_s2_q, pop_s;
  link_state_e state_q;
  logic [2:0] beat_q;
  logic [tof_out_pkg::ENT_W-1:0] word_q;
  logic [3:0] idx_s;

  // Reset release retimed to the link clock
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_rst_q <= tof_out_pkg::LRST_INIT;
    end else begin
      link_rst_q <= {link_rst_q[0], 1'b0};
    end
  end

  always_ff @(posedge link_clk_i or posedge link_rst_q[1]) begin
    if (link_rst_q[1]) begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end else begin
      mode_s1_q <= serial_mode_i;
      mode_s2_q <= mode_s1_q;
    end
  end

  assign rd_if.ready = (state_q == st_idle) || (state_q == st_cmos) ||
                       (state_q == st_serial && beat_q == tof_out_pkg::SER_LAST);
  assign pop_s = rd_if.valid & rd_if.ready;
  assign idx_s = {beat_q, 1'b0};

  always_ff @(posedge link_clk_i or posedge link_rst_q[1]) begin
    if (link_rst_q[1]) begin
      state_q <= st_idle;
      beat_q <= '0;
      word_q <= '0;
    end else if (pop_s) begin
      // Mode is taken per word; a word in flight finishes in its mode
      state_q <= mode_s2_q ? st_serial : st_cmos;
      beat_q <= '0;
      word_q <= rd_if.data;
    end else if (state_q == st_serial && beat_q != tof_out_pkg::SER_LAST) begin
      beat_q <= beat_q + 1'b1;
    end else begin
      state_q <= st_idle;
    end
  end

  always_ff @(posedge link_clk_i or posedge link_rst_q[1]) begin
    if (link_rst_q[1]) begin
      diff_lane_even_o <= 1'b0;
      diff_lane_odd_o <= 1'b0;
      aux_lane_o <= 1'b0;
      pixel_clk_o <= 1'b0;
    end else if (state_q == st_serial) begin
      diff_lane_even_o <= word_q[idx_s];
      diff_lane_odd_o <= word_q[idx_s + 4'h1];
      pixel_clk_o <= (beat_q >= tof_out_pkg::SER_HALF);
      if (beat_q < tof_out_pkg::SER_ID_BEAT) begin
        aux_lane_o <= word_q[tof_out_pkg::PIX_W + 32'(beat_q)];
      end else begin
        aux_lane_o <= (beat_q == tof_out_pkg::SER_ID_BEAT) & word_q[tof_out_pkg::ENT_ID_BIT];
      end
    end else begin
      diff_lane_even_o <= 1'b0;
      diff_lane_odd_o <= 1'b0;
      aux_lane_o <= 1'b0;
      pixel_clk_o <= 1'b0;
    end
  end

  // one word per link cycle, so data moves on both output clock edges
  always_ff @(posedge link_clk_i or posedge link_rst_q[1]) begin
    if (link_rst_q[1]) begin
      cmos_clk_o <= 1'b0;
      cmos_data_o <= '0;
      cmos_valid_o <= 1'b0;
    end else begin
      cmos_clk_o <= ~mode_s2_q & ~cmos_clk_o;
      cmos_valid_o <= (state_q == st_cmos);
      if (state_q == st_cmos) begin
        cmos_data_o <= word_q[tof_out_pkg::WORD_W-1:0];
      end
    end
  end

  // markers held for the whole word
  always_ff @(posedge link_clk_i or posedge link_rst_q[1]) begin
    if (link_rst_q[1]) begin
      frame_marker_o <= 1'b0;
      subframe_marker_o <= 1'b0;
      quad_marker_o <= 1'b0;
      row_marker_o <= 1'b0;
    end else begin
      frame_marker_o <= (state_q != st_idle) & word_q[tof_out_pkg::ENT_MARK_LSB + tof_out_pkg::MARK_FRAME];
      subframe_marker_o <= (state_q != st_idle) & word_q[tof_out_pkg::ENT_MARK_LSB + tof_out_pkg::MARK_SUB];
      quad_marker_o <= (state_q != st_idle) & word_q[tof_out_pkg::ENT_MARK_LSB + tof_out_pkg::MARK_QUAD];
      row_marker_o <= (state_q != st_idle) & word_q[tof_out_pkg::ENT_MARK_LSB + tof_out_pkg::MARK_ROW];
    end
  end

  sequence s_ser_pop;
    pop_s && mode_s2_q;
  endsequence

  sequence s_pclk_frame;
    (!pixel_clk_o) [*3] ##1 pixel_clk_o [*3];
  endsequence

  a_pclk_halves: assert property (@(posedge link_clk_i) disable iff (link_rst_q[1])
    s_ser_pop |-> ##2 s_pclk_frame)
    else $error("pixel clock not low then high over six beats");

  a_even_lane: assert property (@(posedge link_clk_i) disable iff (link_rst_q[1])
    s_ser_pop |-> ##2 diff_lane_even_o == $past(rd_if.data[0], 2) ##1 diff_lane_even_o == $past(rd_if.data[2], 3))
    else $error("even lane does not carry even bits");

  a_odd_lane: assert property (@(posedge link_clk_i) disable iff (link_rst_q[1])
    s_ser_pop |-> ##7 diff_lane_odd_o == $past(rd_if.data[11], 7))
    else $error("odd lane does not end with bit eleven");

  a_cmos_toggle: assert property (@(posedge link_clk_i) disable iff (link_rst_q[1])
    !mode_s2_q && $past(!mode_s2_q) |=> cmos_clk_o != $past(cmos_clk_o))
    else $error("parallel output clock not toggling");

  a_cmos_data: assert property (@(posedge link_clk_i) disable iff (link_rst_q[1])
    pop_s && !mode_s2_q |-> ##2 cmos_valid_o && cmos_data_o == $past(rd_if.data[15:0], 2))
    else $error("parallel word not presented two cycles after pop");

  a_marker_follow: assert property (@(posedge link_clk_i) disable iff (link_rst_q[1])
    pop_s |-> ##2 frame_marker_o == $past(rd_if.data[17], 2) && row_marker_o == $past(rd_if.data[20], 2))
    else $error("marker outputs do not follow their word");

  a_aux_id_flag: assert property (@(posedge link_clk_i) disable iff (link_rst_q[1])
    s_ser_pop |-> ##6 aux_lane_o == $past(rd_if.data[16], 6))
    else $error("third lane does not carry the id flag on beat four");
endmodule : tof_pixel_output

// ---- testbench/host_rx.sv ----
module host_rx (
  input wire logic link_clk_i,
  input wire logic rst_i,
  input wire logic even_i,
  input wire logic odd_i,
  input wire logic aux_i,
  input wire logic pclk_i,
  input wire logic cmos_valid_i,
  input wire logic [15:0] cmos_data_i,
  input wire logic [3:0] marks_i,
  output logic got_o,
  output logic [20:0] entry_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] even_q;
  logic [5:0] odd_q;
  logic [5:0] aux_q;
  logic [5:0] pclk_q;
  logic [23:0] marks_q;

  // Oldest beat in bit 5; LSB first, aux lane holds the top bits
  function automatic logic [20:0] ser_entry();
    logic [15:0] w;
    w = '0;
    for (int k = 0; k < 6; k++) begin
      w[2*k] = even_q[5-k];
      w[2*k+1] = odd_q[5-k];
    end
    for (int k = 0; k < 4; k++) begin
      w[12+k] = aux_q[5-k];
    end
    return {aux_q[1], marks_q[23:20], w};
  endfunction : ser_entry

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      even_q <= '0;
      odd_q <= '0;
      aux_q <= '0;
      pclk_q <= '0;
      marks_q <= '0;
    end else begin
      even_q <= {even_q[4:0], even_i};
      odd_q <= {odd_q[4:0], odd_i};
      aux_q <= {aux_q[4:0], aux_i};
      pclk_q <= {pclk_q[4:0], pclk_i};
      marks_q <= {marks_q[19:0], marks_i};
    end
  end

  // boundary from pclk
  // Only a full low-then-high window counts, so idle zeros never match
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      got_o <= 1'b0;
      entry_o <= '0;
    end else begin
      got_o <= cmos_valid_i | (pclk_q == 6'b000111);
      entry_o <= cmos_valid_i ? {1'b0, marks_i, cmos_data_i} : ser_entry();
    end
  end
endmodule : host_rx

// ---- testbench/testbench.sv ----
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic serial_mode = 1'b0;
  logic [3:0] pos_row = 4'h0;
  logic [3:0] pos_other = 4'h0;
  logic pix_valid = 1'b0;
  logic [11:0] tap_a = 12'h000;
  logic [11:0] tap_b = 12'h000;
  logic [3:0] ev = 4'h0;
  logic [3:0] sf_num = 4'h0;
  logic [3:0] q_num = 4'h0;
  logic chk_ddr = 1'b0;
  logic last_cclk = 1'b0;
  logic pix_ready, even, odd, aux, pclk, cclk, cvalid, got;
  logic fr_mk, sf_mk, qd_mk, row_mk;
  logic [15:0] cdata;
  logic [20:0] entry;
  logic [20:0] got_q[$];
  logic [20:0] exp_q[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;

  always #5 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #80 link_clk = ~link_clk;
  end

  tof_pixel_output u_tof_pixel_output (.ref_clk_i(ref_clk), .rst_i(rst), .link_clk_i(link_clk),
    .serial_mode_i(serial_mode), .pos_frame_i(pos_other), .pos_subframe_i(pos_other),
    .pos_quad_i(pos_other), .pos_row_i(pos_row), .pix_valid_i(pix_valid), .pix_ready_o(pix_ready),
    .tap_a_i(tap_a), .tap_b_i(tap_b), .frame_start_i(ev[0]), .subframe_start_i(ev[1]),
    .quad_start_i(ev[2]), .row_start_i(ev[3]), .subframe_number_i(sf_num), .quad_number_i(q_num),
    .diff_lane_even_o(even), .diff_lane_odd_o(odd), .aux_lane_o(aux), .pixel_clk_o(pclk),
    .cmos_clk_o(cclk), .cmos_data_o(cdata), .cmos_valid_o(cvalid), .frame_marker_o(fr_mk),
    .subframe_marker_o(sf_mk), .quad_marker_o(qd_mk), .row_marker_o(row_mk));

  host_rx u_host_rx (.link_clk_i(link_clk), .rst_i(rst), .even_i(even), .odd_i(odd), .aux_i(aux),
    .pclk_i(pclk), .cmos_valid_i(cvalid), .cmos_data_i(cdata), .marks_i({row_mk, qd_mk, sf_mk, fr_mk}),
    .got_o(got), .entry_o(entry));

  always @(posedge link_clk) begin
    if (got) got_q.push_back(entry);
    if (chk_ddr) `CHK("cmos_clk", ~last_cclk, cclk)
    last_cclk = cclk;
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic set_mode(input logic m);
    @(negedge ref_clk);
    serial_mode = m;
    repeat (8) @(posedge link_clk);
  endtask : set_mode

  // Beat is held until a rising edge sees ready high
  task automatic send(input logic [11:0] a, input logic [11:0] b, input logic [3:0] e,
                      input logic [3:0] s, input logic [3:0] q);
    @(negedge ref_clk);
    pix_valid = 1'b1;
    tap_a = a;
    tap_b = b;
    ev = e;
    sf_num = s;
    q_num = q;
    while (pix_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    pix_valid = 1'b0;
    ev = 4'h0;
  endtask : send

  task automatic expect_w(input logic id, input logic [3:0] mk, input logic [15:0] w);
    exp_q.push_back({id, mk, w});
  endtask : expect_w

  task automatic check_all();
    int n;
    logic [20:0] e_w;
    logic [20:0] g_w;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (16) @(posedge link_clk);
    `CHK("word count", exp_q.size(), got_q.size())
    while (got_q.size() > 0 && exp_q.size() > 0) begin
      e_w = exp_q.pop_front();
      g_w = got_q.pop_front();
      `CHK("word", e_w, g_w)
    end
    got_q.delete();
    exp_q.delete();
  endtask : check_all

  // Id word first, then difference incl. wrap below zero
  task automatic t_serial();
    set_mode(1'b1);
    send(12'h100, 12'h001, 4'b0100, 4'h3, 4'h5);
    send(12'h001, 12'h002, 4'h0, 4'h0, 4'h0);
    send(12'habc, 12'h123, 4'h0, 4'h0, 4'h0);
    expect_w(1'b1, 4'b0100, 16'h5535);
    expect_w(1'b0, 4'h0, 16'h00ff);
    expect_w(1'b0, 4'h0, 16'h0fff);
    expect_w(1'b0, 4'h0, 16'h0999);
    check_all();
  endtask : t_serial

  task automatic t_parallel();
    set_mode(1'b0);
    chk_ddr = 1'b1;
    for (int i = 0; i < 4; i++) begin
      send(12'h800 + 12'(i), 12'h001, 4'b0100, 4'(i), 4'(15 - i));
      expect_w(1'b0, 4'b0100, {8'h55, 4'(i), 4'(15 - i)});
      expect_w(1'b0, 4'h0, 16'h07ff + 16'(i));
    end
    check_all();
    chk_ddr = 1'b0;
  endtask : t_parallel

  // Row marker moved one word later than its event
  task automatic t_markers();
    @(negedge ref_clk);
    pos_row = 4'h1;
    send(12'h005, 12'h003, 4'b0111, 4'h2, 4'h1);
    send(12'h009, 12'h009, 4'b1000, 4'h0, 4'h0);
    send(12'h007, 12'h000, 4'h0, 4'h0, 4'h0);
    expect_w(1'b0, 4'b0111, 16'h5521);
    expect_w(1'b0, 4'h0, 16'h0002);
    expect_w(1'b0, 4'h0, 16'h0000);
    expect_w(1'b0, 4'b1000, 16'h0007);
    check_all();
    @(negedge ref_clk);
    pos_row = 4'h0;
  endtask : t_markers

  // Serial link is slow: buffer fills and input stalls
  task automatic t_stall();
    set_mode(1'b1);
    for (int i = 0; i < 8; i++) begin
      send(12'h111 * 12'(i), 12'h000, 4'h0, 4'h0, 4'h0);
      expect_w(1'b0, 4'h0, 16'h0111 * 16'(i));
    end
    check_all();
  endtask : t_stall

  initial begin
    repeat (8) @(posedge link_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(posedge link_clk);
    t_serial();
    t_parallel();
    t_markers();
    t_stall();
    test_done();
  end
endmodule : testbench
